// ==== pbs_host.sv ====
// Host controller model driving the SRAM port pins
`timescale 1ns/1ps
`default_nettype none
module pbs_host (
  input  wire logic                  i_mclk,
  output var pbs_pkg::pbs_cmd_t      o_cmd,
  output logic                       o_cqn,
  output logic                       o_adv_n,
  output logic [pbs_pkg::DATA_W-1:0] o_dq,
  output logic                       o_wr_phase
);
  logic [pbs_pkg::DATA_W-1:0] cur_d;
  logic [pbs_pkg::DATA_W-1:0] pend_d;
  logic                       pend_w;
  initial begin
    o_cmd = pbs_pkg::CMD_RST;
    o_cqn = 1'b0;
    o_adv_n = 1'b0;
    o_dq = '0;
    o_wr_phase = 1'b0;
    pend_w = 1'b0;
  end
  // Write data goes out one enabled edge after its command, else the bus is inverted
  always @(posedge i_mclk) begin
    if (!o_cqn) begin  // Held edges move nothing
      o_dq       <= pend_w ? pend_d : ~o_dq;
      o_wr_phase <= pend_w;
      pend_w     <= o_cmd.op == pbs_pkg::PBS_WRITE;
      pend_d     <= cur_d;
    end
  end
  task automatic issue(input pbs_pkg::pbs_op_t op, input logic [19:0] a,
                       input logic adv, input logic [3:0] ln,
                       input logic [35:0] d);
    @(posedge i_mclk);
    o_cqn   <= 1'b0;
    o_adv_n <= adv;
    o_cmd   <= '{op: op, addr: a, lane_n: ln};
    cur_d   <= d;
  endtask
  task automatic hold(input logic cq);
    @(posedge i_mclk);
    o_cqn   <= cq;
    o_adv_n <= 1'b0;
    o_cmd   <= pbs_pkg::CMD_RST;
  endtask
endmodule
`default_nettype wire

// ==== pbs_pkg.sv ====
// Package of constants and types for the pipelined burst SRAM port
`default_nettype none
package pbs_pkg;
  localparam int ADDR_W  = 20;
  localparam int DATA_W  = 36;
  localparam int LANES   = 4;
  localparam int LANE_W  = DATA_W / LANES;
  localparam int BURST_W = 2;
  localparam logic [BURST_W-1:0] BURST_FIRST = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP  = 2'h1;
  localparam logic [ADDR_W-1:0]  ADDR_RST    = 20'h0_0000;
  localparam logic [DATA_W-1:0]  DATA_RST    = 36'h0_0000_0000;
  localparam logic [LANES-1:0]   LANES_OFF   = 4'hf;

  // Operation codes, Gray along idle, read, write
  typedef enum logic [1:0] {
    PBS_IDLE  = 2'b00,
    PBS_READ  = 2'b01,
    PBS_WRITE = 2'b11
  } pbs_op_t;

  typedef struct packed {
    pbs_op_t           op;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  lane_n;
  } pbs_cmd_t;

  localparam pbs_cmd_t CMD_RST = '{op: PBS_IDLE, addr: ADDR_RST,
                                   lane_n: LANES_OFF};
endpackage
`default_nettype wire

// ==== pbs_sram_port.sv ====
// Pipelined burst SRAM port with byte writes and output buffer
// Summary of operation
// - Address, control, byte selects and write data register on the clock.
// - Read data leaves via output registers, changing only on the clock.
// - Cycle qualify high freezes every pipeline stage; the output buffer still drains.
// - Only byte lanes whose write selects are low get written.
// - Writes complete internally on the clock, no external write pulse.
// - Select is first low, second high, third low; enable gates drivers.
// - Data drivers are off during the data phase of every write.
// - Reads and writes interleave on consecutive cycles with no idle gaps.
// - Bursts step addresses in linear or interleaved order per mode pin.
// - Storage holds one mega-word of 36 bits, in byte lanes.
`timescale 1ns/1ps
`default_nettype none
module pbs_sram_port (
  input  wire logic                        i_mclk,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_cycle_qualify_n,
  input  wire logic                        i_select_first_n,
  input  wire logic                        i_select_second,
  input  wire logic                        i_select_third_n,
  input  wire logic                        i_write_n,
  input  wire logic                        i_adv_load_n,
  input  wire logic                        i_interleave,
  input  wire logic [pbs_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [pbs_pkg::LANES-1:0]   i_byte_lane_write_n,
  input  wire logic [pbs_pkg::DATA_W-1:0]  i_dq,
  input  wire logic                        i_out_enable_n,
  input  wire logic                        i_rd_ready,
  output logic      [pbs_pkg::DATA_W-1:0]  o_dq,
  output logic                             o_dq_oe_n,
  output logic                             o_rd_valid
);
  localparam int AW = pbs_pkg::ADDR_W;
  localparam int LW = pbs_pkg::LANE_W;
  localparam int BW = pbs_pkg::BURST_W;

  // ---------------------------------------------------------------
  // Pipeline state
  // ---------------------------------------------------------------
  pbs_pkg::pbs_cmd_t s1_r, s2_r, s1_nxt, s2_nxt;
  pbs_pkg::pbs_op_t  bop_r;
  logic [AW-1:0]     base_r;
  logic [BW-1:0]     cnt_r, cnt_nxt, seq;
  logic [pbs_pkg::DATA_W-1:0] rd_word, skid_r;
  logic              head_v_r, skid_v_r, head_v_nxt, drv_n_r;
  logic              en, sel, load, push, pop;

  assign sel  = ~i_select_first_n & i_select_second & ~i_select_third_n;
  assign load = ~i_adv_load_n;
  assign en   = ~i_cycle_qualify_n & ~skid_v_r;
  assign push = en & (s2_r.op == pbs_pkg::PBS_READ);
  assign pop  = head_v_r & i_rd_ready;

  // ---------------------------------------------------------------
  // Next command: new load or burst continuation
  // ---------------------------------------------------------------
  always_comb begin
    cnt_nxt = cnt_r + pbs_pkg::BURST_STEP;
    seq     = i_interleave ? (base_r[BW-1:0] ^ cnt_nxt)
                           : (base_r[BW-1:0] + cnt_nxt);
    s1_nxt  = pbs_pkg::CMD_RST;
    if (load) begin
      s1_nxt.addr = i_addr;
      if (sel) begin
        s1_nxt.op = i_write_n ? pbs_pkg::PBS_READ : pbs_pkg::PBS_WRITE;
      end
    end else if (bop_r != pbs_pkg::PBS_IDLE) begin
      s1_nxt.op   = bop_r;
      s1_nxt.addr = {base_r[AW-1:BW], seq};
    end
    s1_nxt.lane_n = i_byte_lane_write_n;
    s2_nxt        = en ? s1_r : s2_r;
    head_v_nxt    = head_v_r;
    if (!head_v_r || pop) begin
      head_v_nxt = skid_v_r | push;
    end
  end

  // ---------------------------------------------------------------
  // Input registers and burst tracking
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      s1_r   <= pbs_pkg::CMD_RST;
      s2_r   <= pbs_pkg::CMD_RST;
      bop_r  <= pbs_pkg::PBS_IDLE;
      base_r <= pbs_pkg::ADDR_RST;
      cnt_r  <= pbs_pkg::BURST_FIRST;
    end else if (en) begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      if (load) begin
        bop_r  <= s1_nxt.op;
        base_r <= i_addr;
        cnt_r  <= pbs_pkg::BURST_FIRST;
      end else if (bop_r != pbs_pkg::PBS_IDLE) begin
        cnt_r <= cnt_nxt;
      end
    end
  end

  // ---------------------------------------------------------------
  // Storage array, one memory per byte lane
  // ---------------------------------------------------------------
  for (genvar l = 0; l < pbs_pkg::LANES; l++) begin : g_lane
    logic [LW-1:0] mem [2**AW];
    always_ff @(posedge i_mclk) begin
      if (en && s2_r.op == pbs_pkg::PBS_WRITE && !s2_r.lane_n[l]) begin
        mem[s2_r.addr] <= i_dq[l*LW +: LW];
      end
    end
    assign rd_word[l*LW +: LW] = mem[s2_r.addr];
  end

  // ---------------------------------------------------------------
  // Two-entry output buffer, head register drives the pins
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_dq     <= pbs_pkg::DATA_RST;
      skid_r   <= pbs_pkg::DATA_RST;
      head_v_r <= 1'b0;
      skid_v_r <= 1'b0;
    end else begin
      head_v_r <= head_v_nxt;
      if (!head_v_r || pop) begin
        if (skid_v_r) begin
          o_dq     <= skid_r;
          skid_v_r <= 1'b0;
        end else if (push) begin
          o_dq <= rd_word;
        end
      end else if (push) begin
        skid_r   <= rd_word;
        skid_v_r <= 1'b1;
      end
    end
  end

  assign o_rd_valid = head_v_r;

  // ---------------------------------------------------------------
  // Output driver control
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      drv_n_r <= 1'b1;
    end else begin
      drv_n_r <= ~head_v_nxt | (s2_nxt.op == pbs_pkg::PBS_WRITE);
    end
  end

  assign o_dq_oe_n = drv_n_r | i_out_enable_n;

  // ---------------------------------------------------------------
  // Pipeline checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  sequence seq_rd_at_s2;
    en && s2_r.op == pbs_pkg::PBS_READ;
  endsequence
  sequence seq_load_sel;
    en && load && sel;
  endsequence
  sequence seq_load_wr;
    seq_load_sel ##0 !i_write_n;
  endsequence

  a_ignore_edge: assert property (
    !en |=> $stable(s1_r) && $stable(s2_r))
    else $error("Pipeline moved on a disqualified edge");
  a_addr_capture: assert property (
    en && load |=> s1_r.addr == $past(i_addr))
    else $error("Address not captured");
  a_read_latency: assert property (
    seq_load_sel ##0 i_write_n ##1 (en ##1 seq_rd_at_s2)
      |=> o_rd_valid)
    else $error("Read data missing two edges after address");
  a_write_latency: assert property (
    seq_load_wr ##1 en |=> s2_r.op == pbs_pkg::PBS_WRITE)
    else $error("Write not at data stage two edges after address");
  a_deselect_idle: assert property (
    en && load && !sel |=> s1_r.op == pbs_pkg::PBS_IDLE)
    else $error("Deselected cycle not idle");
  a_back_to_back: assert property (
    en |=> s2_r.op == $past(s1_r.op))
    else $error("Pipeline inserted a gap");
  a_burst_step: assert property (
    en && !load && bop_r != pbs_pkg::PBS_IDLE
      |=> cnt_r == $past(cnt_nxt))
    else $error("Burst counter did not step");
  a_lane_write: assert property (
    en && s2_r.op == pbs_pkg::PBS_WRITE && !s2_r.lane_n[0]
      |=> g_lane[0].mem[$past(s2_r.addr)] == $past(i_dq[LW-1:0]))
    else $error("Selected lane not written");
  a_lane_keep: assert property (
    en && s2_r.op == pbs_pkg::PBS_WRITE && s2_r.lane_n[0]
      |=> g_lane[0].mem[$past(s2_r.addr)]
          == $past(g_lane[0].mem[s2_r.addr]))
    else $error("Unselected lane was written");

  // ---------------------------------------------------------------
  // Output checks
  // ---------------------------------------------------------------
  a_write_hiz: assert property (
    s2_r.op == pbs_pkg::PBS_WRITE |-> o_dq_oe_n)
    else $error("Drivers on during write data phase");
  a_read_drive: assert property (
    o_rd_valid && !i_out_enable_n && s2_r.op != pbs_pkg::PBS_WRITE
      |-> !o_dq_oe_n)
    else $error("Drivers off while read data waits");
  a_oe_gate: assert property (
    i_out_enable_n |-> o_dq_oe_n)
    else $error("Drivers on with output enable high");
  a_out_hold: assert property (
    o_rd_valid && !i_rd_ready |=> o_rd_valid && $stable(o_dq))
    else $error("Output word lost under stall");
  a_rd_data: assert property (
    seq_rd_at_s2 ##0 (!head_v_r || pop) |=> o_dq == $past(rd_word))
    else $error("Read word not registered to the pins");
  a_skid_hold: assert property (
    skid_v_r && !pop |=> skid_v_r && $stable(skid_r))
    else $error("Buffered word lost while stalled");
endmodule
`default_nettype wire

// ==== pbs_sram_port_test.sv ====
// Testbench for the pipelined burst SRAM port
`timescale 1ns/1ps
`default_nettype none
module pbs_sram_port_test;
  logic              mclk = 1'b0;
  logic              rst_n = 1'b0;
  logic              oe_n = 1'b0;
  logic              rd_ready = 1'b1;
  logic              ilv = 1'b0;
  logic              sel_second = 1'b1;
  logic              sel_third_n = 1'b0;
  pbs_pkg::pbs_cmd_t cmd;
  logic              cqn, adv_n, wr_ph, dq_oe_n, rd_valid;
  logic [35:0]       hdq, dq;
  logic [35:0]       exp_q[$];
  int                bad_count = 0, samples_checked = 0, cycles = 0;
  initial forever #5 mclk = ~mclk;
  pbs_sram_port i_pbs_sram_port (.i_mclk(mclk), .i_rst_n(rst_n),
    .i_cycle_qualify_n(cqn), .i_select_first_n(cmd.op == pbs_pkg::PBS_IDLE),
    .i_select_second(sel_second), .i_select_third_n(sel_third_n),
    .i_write_n(cmd.op != pbs_pkg::PBS_WRITE), .i_adv_load_n(adv_n),
    .i_interleave(ilv), .i_addr(cmd.addr), .i_byte_lane_write_n(cmd.lane_n),
    .i_dq(hdq), .i_out_enable_n(oe_n), .i_rd_ready(rd_ready), .o_dq(dq),
    .o_dq_oe_n(dq_oe_n), .o_rd_valid(rd_valid));
  pbs_host i_pbs_host (.i_mclk(mclk), .o_cmd(cmd), .o_cqn(cqn),
    .o_adv_n(adv_n), .o_dq(hdq), .o_wr_phase(wr_ph));
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Words taken are compared in order, drivers checked off in write data
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      end_of_test();
    end else begin
      if (rd_valid === 1'b1 && rd_ready)
        check(dq, exp_q.size() > 0 ? exp_q.pop_front() : ~dq);
      if (wr_ph === 1'b1 && !cqn) check({35'h0, dq_oe_n}, 36'h1);
    end
  end
  task automatic drain();
    for (int i = 0; i < 30 && exp_q.size() > 0; i++) i_pbs_host.hold(1'b0);
    check(36'(exp_q.size()), 36'h0);
  endtask
  task automatic t_bytes();
    i_pbs_host.issue(pbs_pkg::PBS_WRITE, 20'h10, 1'b0, 4'h0, 36'h1_2345_6789);
    i_pbs_host.issue(pbs_pkg::PBS_WRITE, 20'h10, 1'b0, 4'h5, 36'hf_edcb_a987);
    i_pbs_host.issue(pbs_pkg::PBS_READ, 20'h10, 1'b0, 4'hf, '0);
    i_pbs_host.issue(pbs_pkg::PBS_WRITE, 20'h11, 1'b0, 4'h0, 36'h5_0a0a_0a0a);
    i_pbs_host.issue(pbs_pkg::PBS_READ, 20'h11, 1'b0, 4'hf, '0);
    exp_q.push_back(36'hf_eb47_a989);
    exp_q.push_back(36'h5_0a0a_0a0a);
    drain();
  endtask
  task automatic t_burst();
    for (int a = 4; a < 8; a++)
      i_pbs_host.issue(pbs_pkg::PBS_WRITE, 20'(a), 1'b0, 4'h0, 36'(a + 'ha00));
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 4; i++) begin
        i_pbs_host.issue(pbs_pkg::PBS_READ, 20'h5, i != 0, 4'hf, '0);
        if (i == 0) ilv <= m[0];
        exp_q.push_back(36'ha00 +
                        36'(m ? 5 ^ i : 4 + ((1 + i) & 3)));
      end
    end
    drain();
  endtask
  task automatic t_stall();
    i_pbs_host.issue(pbs_pkg::PBS_READ, 20'h4, 1'b0, 4'hf, '0);
    exp_q.push_back(36'ha04);
    repeat (3) i_pbs_host.hold(1'b1);
    #1 check({35'h0, rd_valid}, 36'h0);
    drain();
  endtask
  task automatic t_buffer();
    rd_ready <= 1'b0;
    i_pbs_host.issue(pbs_pkg::PBS_READ, 20'h5, 1'b0, 4'hf, '0);
    i_pbs_host.issue(pbs_pkg::PBS_READ, 20'h6, 1'b0, 4'hf, '0);
    exp_q.push_back(36'ha05);
    exp_q.push_back(36'ha06);
    repeat (6) i_pbs_host.hold(1'b0);
    #1 check({rd_valid, dq_oe_n, dq[33:0]}, 36'h8_0000_0a05);
    @(posedge mclk);
    oe_n <= 1'b1;
    #1 check({35'h0, dq_oe_n}, 36'h1);
    @(posedge mclk);
    oe_n <= 1'b0;
    rd_ready <= 1'b1;
    drain();
  endtask
  task automatic t_select();
    i_pbs_host.issue(pbs_pkg::PBS_READ, 20'h6, 1'b0, 4'hf, '0);
    i_pbs_host.issue(pbs_pkg::PBS_READ, 20'h7, 1'b0, 4'hf, '0);
    sel_second <= 1'b0;
    i_pbs_host.issue(pbs_pkg::PBS_READ, 20'h4, 1'b0, 4'hf, '0);
    sel_second <= 1'b1;
    sel_third_n <= 1'b1;
    i_pbs_host.issue(pbs_pkg::PBS_READ, 20'h5, 1'b0, 4'hf, '0);
    sel_third_n <= 1'b0;
    exp_q.push_back(36'ha06);
    exp_q.push_back(36'ha05);
    drain();
  endtask
  initial begin
    @(posedge mclk);
    #1 check({rd_valid, dq_oe_n, dq[33:0]}, 36'h4_0000_0000);
    @(posedge mclk);
    rst_n <= 1'b1;
    t_bytes();
    t_burst();
    t_stall();
    t_buffer();
    t_select();
    end_of_test();
  end
endmodule
`default_nettype wire
